// ### design/cfp_pkg.sv
package cfp_pkg;
	// Address space
	localparam logic [21:0] CFG_BASE = 22'h300000;
	localparam logic [21:0] CFG_WP_TOP = 22'h3000FF;
	localparam logic [21:0] BOOT_TOP = 22'h0001FF;
	localparam logic [21:0] USER_TOP = 22'h007FFF;
	localparam int BLOCK_LSB = 13;
	// Register byte addresses
	localparam logic [21:0] ADDR_DEBUG_LVP_STACK_FUSES = 22'h300006;
	localparam logic [21:0] ADDR_CODE_PROTECT_BLOCKS = 22'h300008;
	localparam logic [21:0] ADDR_CODE_PROTECT_BOOT_EEPROM = 22'h300009;
	localparam logic [21:0] ADDR_WRITE_PROTECT_BLOCKS = 22'h30000A;
	localparam logic [21:0] ADDR_WRITE_PROTECT_BOOT_EEPROM_CFG = 22'h30000B;
	localparam logic [21:0] ADDR_TABLE_READ_PROTECT_BLOCKS = 22'h30000C;
	localparam logic [21:0] ADDR_TABLE_READ_PROTECT_BOOT = 22'h30000D;
	localparam logic [21:0] ADDR_PART_ID_LOW_AND_REVISION = 22'h3FFFFE;
	localparam logic [21:0] ADDR_PART_ID_HIGH = 22'h3FFFFF;
	// Fuse array indices, counted from the first fuse byte
	localparam int FUSE_COUNT = 8;
	localparam logic [2:0] IDX_DEBUG_LVP_STACK = 3'h0;
	localparam logic [2:0] IDX_CODE_PROTECT_BLOCKS = 3'h2;
	localparam logic [2:0] IDX_CODE_PROTECT_BOOT_EEPROM = 3'h3;
	localparam logic [2:0] IDX_WRITE_PROTECT_BLOCKS = 3'h4;
	localparam logic [2:0] IDX_WRITE_PROTECT_BOOT_EEPROM_CFG = 3'h5;
	localparam logic [2:0] IDX_TABLE_READ_PROTECT_BLOCKS = 3'h6;
	localparam logic [2:0] IDX_TABLE_READ_PROTECT_BOOT = 3'h7;
	// Bit positions
	localparam int BIT_BACKGROUND_DEBUGGER = 7;
	localparam int BIT_LOW_VOLTAGE_PROG = 2;
	localparam int BIT_STACK_FAULT_RESET = 0;
	localparam int BIT_EEPROM_CODE_PROTECT = 7;
	localparam int BIT_BOOT_CODE_PROTECT = 6;
	localparam int BIT_EEPROM_WRITE_PROTECT = 7;
	localparam int BIT_BOOT_WRITE_PROTECT = 6;
	localparam int BIT_CONFIG_WRITE_PROTECT = 5;
	localparam int BIT_BOOT_TABLE_READ_PROTECT = 6;
	// Implemented bits, the unprogrammed value equals the mask; MASK_USER_LOCKED marks the user-locked bit
	localparam logic [7:0] MASK_DEBUG_LVP_STACK = 8'h85;
	localparam logic [7:0] MASK_BLOCKS = 8'h0F;
	localparam logic [7:0] MASK_CODE_PROTECT_HIGH = 8'hC0;
	localparam logic [7:0] MASK_WRITE_PROTECT_HIGH = 8'hE0;
	localparam logic [7:0] MASK_TABLE_READ_HIGH = 8'h40;
	localparam logic [7:0] MASK_NONE = 8'h00;
	localparam logic [7:0] MASK_USER_LOCKED = 8'h20;

	typedef enum logic [2:0] {
		KIND_NONE = 3'b000,
		KIND_TABLE_READ = 3'b001,
		KIND_TABLE_WRITE = 3'b010,
		KIND_PROG_READ = 3'b011,
		KIND_PROG_WRITE = 3'b100
	} cfp_kind_t;

	typedef struct packed {
		logic valid;
		cfp_kind_t kind;
		logic eeprom;
		logic [21:0] addr;
		logic [21:0] exec_addr;
		logic [7:0] wdata;
	} cfp_req_t;

	typedef struct packed {
		logic ack;
		logic deny;
		logic cfg;
		logic [7:0] rdata;
	} cfp_rsp_t;
endpackage : cfp_pkg

// ### design/cfp_fuse_protect.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Debugger fuse 0 reserves port B pins 6 and 7; 1 frees them.
// RULE2 - Low-voltage programming entry allowed while its fuse is 1.
// RULE3 - Stack fault forces reset only while stack reset fuse is 1.
// RULE4 - Block 0 code protect covers 000200h-001FFFh; 0 protects.
// RULE5 - Block 1 code protect covers 002000h-003FFFh; 0 protects.
// RULE6 - Blocks 2 and 3 code protect their 8K ranges; 0 protects.
// RULE7 - Smaller parts: programmer keeps block 2 and 3 bits at 1.
// RULE8 - EEPROM code protect bit 0 protects data EEPROM.
// RULE9 - Boot code protect bit 0 protects 000000h-0001FFh.
// RULE10 - Block 0 write protect blocks writes to 000000h-001FFFh, boot included.
// RULE11 - Blocks 1 to 3 write protect bits block writes to their ranges.
// RULE12 - EEPROM write protect bit 0 blocks data EEPROM writes.
// RULE13 - Boot write protect bit 0 blocks writes to 000000h-0001FFh.
// RULE14 - Config write protect bit 0 blocks writes to 300000h-3000FFh.
// RULE15 - Config write protect is readable; only the programmer changes it.
// RULE16 - Block 0 table read protect refuses reads from code in other blocks.
// RULE17 - Blocks 1 to 3 table read protect likewise refuse cross-block reads.
// RULE18 - Boot table read protect refuses reads from code outside boot.
// RULE19 - Code protect bits start at 1 and user writes can only clear.
// RULE20 - Unimplemented fuse bits always read as 0.
// RULE21 - First ID byte: 3-bit part code high, 5-bit revision low.
// RULE22 - Second ID byte: eight more part code bits, 11 bits total.
// RULE23 - Fuse bits read 0 when programmed, 1 when unprogrammed.
// RULE24 - Config space reached only by table accesses, one byte each; programmer reads and writes also reach it.
// RULE25 - Accesses checked against block bounds; denial returned instead of data.
module cfp_fuse_protect
	import cfp_pkg::*;
#(
	// Arbitrary neutral identity values
	parameter logic [10:0] PART_CODE = 11'h7E6,
	parameter logic [4:0] REVISION = 5'h03
)
(
	// Clock, reset, enable
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CE,
	// Programmer presence pin
	input wire logic PROG_MODE,
	// Access request and answer
	input wire cfp_req_t REQ,
	output cfp_rsp_t RSP,
	// Core events and fuse-driven controls
	input wire logic STACK_FAULT,
	output logic STACK_RESET,
	output logic DEBUG_PINS_RESERVED,
	output logic LVP_ENTRY_EN
);

	logic [7:0] fuse [0:FUSE_COUNT-1];
	logic prog_meta;
	logic prog_sync;
	logic next_deny;
	logic next_cfg;
	logic [7:0] next_rdata;
	logic fuse_we;
	logic [7:0] fuse_wval;
	logic [2:0] req_idx;

	logic background_debugger_fuse;
	logic low_voltage_programming_enable;
	logic stack_fault_reset_enable;
	logic [3:0] code_protect_blocks;
	logic eeprom_code_protect;
	logic boot_code_protect;
	logic [3:0] write_protect_blocks;
	logic eeprom_write_protect;
	logic boot_write_protect;
	logic config_write_protect;
	logic [3:0] table_read_protect_blocks;
	logic boot_table_read_protect;

	function automatic logic is_cfg(input logic [21:0] a);
		is_cfg = (a >= CFG_BASE);
	endfunction : is_cfg

	function automatic logic is_user(input logic [21:0] a);
		is_user = (a <= USER_TOP);
	endfunction : is_user

	function automatic logic is_boot(input logic [21:0] a);
		is_boot = (a <= BOOT_TOP);
	endfunction : is_boot

	function automatic logic [1:0] block_of(input logic [21:0] a);
		block_of = a[BLOCK_LSB+1:BLOCK_LSB];
	endfunction : block_of

	function automatic logic is_fuse(input logic [21:0] a);
		is_fuse = (a >= ADDR_DEBUG_LVP_STACK_FUSES) && (a <= ADDR_TABLE_READ_PROTECT_BOOT);
	endfunction : is_fuse

	function automatic logic [2:0] fuse_index(input logic [21:0] a);
		logic [21:0] d;
		d = a - ADDR_DEBUG_LVP_STACK_FUSES;
		fuse_index = d[2:0];
	endfunction : fuse_index

	// Implemented bits of each fuse byte; also its unprogrammed value
	function automatic logic [7:0] fuse_mask(input logic [2:0] i);
		case (i)
			IDX_DEBUG_LVP_STACK: fuse_mask = MASK_DEBUG_LVP_STACK;
			IDX_CODE_PROTECT_BLOCKS: fuse_mask = MASK_BLOCKS;
			IDX_CODE_PROTECT_BOOT_EEPROM: fuse_mask = MASK_CODE_PROTECT_HIGH;
			IDX_WRITE_PROTECT_BLOCKS: fuse_mask = MASK_BLOCKS;
			IDX_WRITE_PROTECT_BOOT_EEPROM_CFG: fuse_mask = MASK_WRITE_PROTECT_HIGH;
			IDX_TABLE_READ_PROTECT_BLOCKS: fuse_mask = MASK_BLOCKS;
			IDX_TABLE_READ_PROTECT_BOOT: fuse_mask = MASK_TABLE_READ_HIGH;
			default: fuse_mask = MASK_NONE;
		endcase
	endfunction : fuse_mask

	// Bits that user code may only clear
	function automatic logic [7:0] clear_only_mask(input logic [2:0] i);
		case (i)
			IDX_CODE_PROTECT_BLOCKS: clear_only_mask = MASK_BLOCKS;
			IDX_CODE_PROTECT_BOOT_EEPROM: clear_only_mask = MASK_CODE_PROTECT_HIGH;
			default: clear_only_mask = MASK_NONE;
		endcase
	endfunction : clear_only_mask

	// Bits that user code cannot change at all
	function automatic logic [7:0] user_locked_mask(input logic [2:0] i);
		case (i)
			IDX_WRITE_PROTECT_BOOT_EEPROM_CFG: user_locked_mask = MASK_USER_LOCKED;
			default: user_locked_mask = MASK_NONE;
		endcase
	endfunction : user_locked_mask

	assign background_debugger_fuse = fuse[IDX_DEBUG_LVP_STACK][BIT_BACKGROUND_DEBUGGER];
	assign low_voltage_programming_enable = fuse[IDX_DEBUG_LVP_STACK][BIT_LOW_VOLTAGE_PROG];
	assign stack_fault_reset_enable = fuse[IDX_DEBUG_LVP_STACK][BIT_STACK_FAULT_RESET];
	assign code_protect_blocks = fuse[IDX_CODE_PROTECT_BLOCKS][3:0];
	assign eeprom_code_protect = fuse[IDX_CODE_PROTECT_BOOT_EEPROM][BIT_EEPROM_CODE_PROTECT];
	assign boot_code_protect = fuse[IDX_CODE_PROTECT_BOOT_EEPROM][BIT_BOOT_CODE_PROTECT];
	assign write_protect_blocks = fuse[IDX_WRITE_PROTECT_BLOCKS][3:0];
	assign eeprom_write_protect = fuse[IDX_WRITE_PROTECT_BOOT_EEPROM_CFG][BIT_EEPROM_WRITE_PROTECT];
	assign boot_write_protect = fuse[IDX_WRITE_PROTECT_BOOT_EEPROM_CFG][BIT_BOOT_WRITE_PROTECT];
	assign config_write_protect = fuse[IDX_WRITE_PROTECT_BOOT_EEPROM_CFG][BIT_CONFIG_WRITE_PROTECT];
	assign table_read_protect_blocks = fuse[IDX_TABLE_READ_PROTECT_BLOCKS][3:0];
	assign boot_table_read_protect = fuse[IDX_TABLE_READ_PROTECT_BOOT][BIT_BOOT_TABLE_READ_PROTECT];
	assign req_idx = fuse_index(REQ.addr);

	// Programmer pin synchroniser
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			prog_meta <= 1'b0;
			prog_sync <= 1'b0;
		end
		else if (CE)
		begin
			prog_meta <= PROG_MODE;
			prog_sync <= prog_meta;
		end
	end

	// Access decision and config-space data
	always_comb
	begin
		next_deny = 1'b0;
		next_cfg = 1'b0;
		next_rdata = 8'h00;
		fuse_we = 1'b0;
		fuse_wval = 8'h00;
		if (REQ.valid)
		begin
			case (REQ.kind)
				KIND_TABLE_READ, KIND_PROG_READ:
				begin
					if ((REQ.kind == KIND_PROG_READ) && !prog_sync)
						next_deny = 1'b1;
					else if (!REQ.eeprom && is_cfg(REQ.addr))
					begin
						next_cfg = 1'b1; // RULE24
						if (is_fuse(REQ.addr))
							next_rdata = fuse[req_idx] & fuse_mask(req_idx); // RULE20
						else if (REQ.addr == ADDR_PART_ID_LOW_AND_REVISION)
							next_rdata = {PART_CODE[2:0], REVISION}; // RULE21
						else if (REQ.addr == ADDR_PART_ID_HIGH)
							next_rdata = PART_CODE[10:3]; // RULE22
					end
					else if (REQ.kind == KIND_PROG_READ)
					begin
						// Code protection keeps the programmer from reading out
						if (REQ.eeprom)
							next_deny = !eeprom_code_protect; // RULE8
						else if (is_boot(REQ.addr))
							next_deny = !boot_code_protect; // RULE9
						else if (is_user(REQ.addr))
							next_deny = !code_protect_blocks[block_of(REQ.addr)]; // RULE4 RULE5 RULE6
					end
					else if (!REQ.eeprom && is_user(REQ.addr))
					begin
						// Table reads from code running elsewhere are refused
						if (is_boot(REQ.addr) && !boot_table_read_protect && !is_boot(REQ.exec_addr))
							next_deny = 1'b1; // RULE18
						if (!table_read_protect_blocks[block_of(REQ.addr)]
							&& (!is_user(REQ.exec_addr) || (block_of(REQ.exec_addr) != block_of(REQ.addr))))
							next_deny = 1'b1; // RULE16 RULE17 RULE25
					end
				end
				KIND_TABLE_WRITE, KIND_PROG_WRITE:
				begin
					if ((REQ.kind == KIND_PROG_WRITE) && !prog_sync)
						next_deny = 1'b1;
					else if (REQ.eeprom)
						next_deny = !eeprom_write_protect; // RULE12
					else if (is_cfg(REQ.addr))
					begin
						next_cfg = 1'b1;
						if ((REQ.kind == KIND_TABLE_WRITE) && !config_write_protect && (REQ.addr <= CFG_WP_TOP))
							next_deny = 1'b1; // RULE14
						else if (is_fuse(REQ.addr))
						begin
							fuse_we = 1'b1; // RULE24
							if (REQ.kind == KIND_PROG_WRITE)
								fuse_wval = REQ.wdata & fuse_mask(req_idx);
							else
								fuse_wval = ((REQ.wdata & ~clear_only_mask(req_idx) & ~user_locked_mask(req_idx))
									| (REQ.wdata & fuse[req_idx] & clear_only_mask(req_idx))
									| (fuse[req_idx] & user_locked_mask(req_idx)))
									& fuse_mask(req_idx); // RULE15 RULE19 RULE20
						end
					end
					else
					begin
						if (is_boot(REQ.addr) && !boot_write_protect)
							next_deny = 1'b1; // RULE13
						if (is_user(REQ.addr) && !write_protect_blocks[block_of(REQ.addr)])
							next_deny = 1'b1; // RULE10 RULE11
					end
				end
				default:
				begin
					next_deny = 1'b1;
				end
			endcase
		end
	end

	// Fuse storage; reset shows the unprogrammed image
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			for (int i = 0; i < FUSE_COUNT; i++)
				fuse[i] <= fuse_mask(3'(i)); // RULE23
		end
		else if (CE && fuse_we)
		begin
			fuse[req_idx] <= fuse_wval;
		end
	end

	// Registered answer, one cycle after the request
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			RSP <= '0;
		end
		else if (CE)
		begin
			RSP.ack <= REQ.valid;
			RSP.deny <= REQ.valid && next_deny; // RULE25
			RSP.cfg <= REQ.valid && next_cfg;
			RSP.rdata <= (REQ.valid && !next_deny) ? next_rdata : 8'h00;
		end
	end

	// Fuse-driven controls
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			DEBUG_PINS_RESERVED <= 1'b0;
			LVP_ENTRY_EN <= 1'b0;
			STACK_RESET <= 1'b0;
		end
		else if (CE)
		begin
			DEBUG_PINS_RESERVED <= !background_debugger_fuse; // RULE1
			LVP_ENTRY_EN <= low_voltage_programming_enable; // RULE2
			STACK_RESET <= STACK_FAULT && stack_fault_reset_enable; // RULE3
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	a_debug_pins_follow: assert property (CE && !background_debugger_fuse && !fuse_we |=> DEBUG_PINS_RESERVED) // RULE1
		else $error("debug pins not reserved while debugger fuse is 0");
	a_lvp_entry_follow: assert property (CE |=> LVP_ENTRY_EN == $past(low_voltage_programming_enable)) // RULE2
		else $error("low-voltage entry enable does not follow its fuse");
	a_stack_reset_gate: assert property (CE && STACK_FAULT |=> STACK_RESET == $past(stack_fault_reset_enable)) // RULE3
		else $error("stack fault reset not gated by its fuse");
	a_cp_clear_only: assert property (CE && !prog_sync // RULE19
		|=> (code_protect_blocks & ~$past(code_protect_blocks)) == 4'h0)
		else $error("code protect bit set back by user write");
	a_cfg_wp_locked: assert property (CE && !prog_sync |=> $stable(config_write_protect)) // RULE15
		else $error("config write protect changed outside programmer mode");
	a_unimpl_zero: assert property ( // RULE20
		(fuse[IDX_WRITE_PROTECT_BOOT_EEPROM_CFG] & ~MASK_WRITE_PROTECT_HIGH) == 8'h00
		&& (fuse[IDX_DEBUG_LVP_STACK] & ~MASK_DEBUG_LVP_STACK) == 8'h00)
		else $error("unimplemented fuse bit is set");
	a_cp_unimpl_zero: assert property ( // RULE20
		(fuse[IDX_CODE_PROTECT_BLOCKS] & ~MASK_BLOCKS) == 8'h00
		&& (fuse[IDX_CODE_PROTECT_BOOT_EEPROM] & ~MASK_CODE_PROTECT_HIGH) == 8'h00)
		else $error("unimplemented code protect bit is set");
	a_wp_block_deny: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_WRITE && !REQ.eeprom // RULE10
		&& is_user(REQ.addr) && !write_protect_blocks[block_of(REQ.addr)] |=> RSP.ack && RSP.deny)
		else $error("write into write-protected block not refused");
	a_unprot_write_ok: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_WRITE && !REQ.eeprom // RULE11
		&& is_user(REQ.addr) && !is_boot(REQ.addr) && write_protect_blocks[block_of(REQ.addr)] |=> !RSP.deny)
		else $error("write into open block refused");
	a_boot_wp_deny: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_WRITE && !REQ.eeprom // RULE13
		&& is_boot(REQ.addr) && !boot_write_protect |=> RSP.deny)
		else $error("write into protected boot block not refused");
	a_eeprom_wp_deny: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_WRITE && REQ.eeprom // RULE12
		&& !eeprom_write_protect |=> RSP.deny)
		else $error("write into protected EEPROM not refused");
	a_cfg_wp_deny: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_WRITE && !REQ.eeprom // RULE14
		&& is_cfg(REQ.addr) && REQ.addr <= CFG_WP_TOP && !config_write_protect
		|=> RSP.deny ##0 $stable(code_protect_blocks))
		else $error("config write not refused while protected");
	a_cross_read_deny: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_READ && !REQ.eeprom // RULE16
		&& is_user(REQ.addr) && !table_read_protect_blocks[block_of(REQ.addr)]
		&& block_of(REQ.exec_addr) != block_of(REQ.addr) |=> RSP.deny && RSP.rdata == 8'h00)
		else $error("cross-block table read not refused");
	a_same_block_read: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_READ && !REQ.eeprom // RULE17
		&& is_user(REQ.addr) && !is_boot(REQ.addr) && is_user(REQ.exec_addr)
		&& block_of(REQ.exec_addr) == block_of(REQ.addr) |=> !RSP.deny)
		else $error("table read from its own block refused");
	a_boot_read_deny: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_READ && !REQ.eeprom // RULE18
		&& is_boot(REQ.addr) && !boot_table_read_protect && !is_boot(REQ.exec_addr) |=> RSP.deny)
		else $error("boot table read from outside not refused");
	a_part_id_read: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_READ && !REQ.eeprom // RULE21
		&& REQ.addr == ADDR_PART_ID_LOW_AND_REVISION |=> RSP.cfg && RSP.rdata == {PART_CODE[2:0], REVISION})
		else $error("first identification byte wrong");
	a_part_id_high: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_READ && !REQ.eeprom // RULE22
		&& REQ.addr == ADDR_PART_ID_HIGH |=> RSP.cfg && RSP.rdata == PART_CODE[10:3])
		else $error("second identification byte wrong");
	a_cfg_table_read: assert property (CE && REQ.valid && REQ.kind == KIND_TABLE_READ && !REQ.eeprom // RULE24
		&& is_cfg(REQ.addr) |=> RSP.cfg && !RSP.deny)
		else $error("config space table read not answered");
	a_ext_read_cp: assert property (CE && REQ.valid && REQ.kind == KIND_PROG_READ && prog_sync // RULE8
		&& REQ.eeprom && !eeprom_code_protect |=> RSP.deny)
		else $error("protected EEPROM readout not refused");
	a_ext_read_open: assert property (CE && REQ.valid && REQ.kind == KIND_PROG_READ && prog_sync // RULE8
		&& REQ.eeprom && eeprom_code_protect |=> !RSP.deny)
		else $error("open EEPROM readout refused");
	a_boot_cp_read: assert property (CE && REQ.valid && REQ.kind == KIND_PROG_READ && prog_sync // RULE9
		&& !REQ.eeprom && is_boot(REQ.addr) && !boot_code_protect |=> RSP.deny)
		else $error("protected boot block readout not refused");
	a_block_cp_read: assert property (CE && REQ.valid && REQ.kind == KIND_PROG_READ // RULE4 RULE5 RULE6
		&& prog_sync && !REQ.eeprom && !is_boot(REQ.addr) && is_user(REQ.addr)
		&& !code_protect_blocks[block_of(REQ.addr)] |=> RSP.deny)
		else $error("protected block readout not refused");
	a_prog_needs_pin: assert property (CE && REQ.valid && !prog_sync // RULE15
		&& (REQ.kind == KIND_PROG_READ || REQ.kind == KIND_PROG_WRITE) |=> RSP.deny)
		else $error("programmer access granted without the programmer pin");
	a_ack_follows_req: assert property (CE |=> RSP.ack == $past(REQ.valid)) // RULE25
		else $error("answer strobe does not follow the request");
	a_stack_reset_quiet: assert property (CE && !STACK_FAULT |=> !STACK_RESET) // RULE3
		else $error("stack reset without a stack fault");
	a_debug_pins_free: assert property (CE && background_debugger_fuse |=> !DEBUG_PINS_RESERVED) // RULE1
		else $error("debug pins reserved while debugger fuse is 1");

	c_cross_read: cover property (CE && REQ.valid && REQ.kind == KIND_TABLE_READ ##1 RSP.deny);
	c_cp_cleared: cover property (CE && fuse_we && req_idx == IDX_CODE_PROTECT_BLOCKS ##1 code_protect_blocks != 4'hF);
	c_stack_reset: cover property (STACK_RESET);
	c_prog_write: cover property (CE && REQ.valid && REQ.kind == KIND_PROG_WRITE && fuse_we);
	c_write_denied: cover property (CE && REQ.valid && REQ.kind == KIND_TABLE_WRITE ##1 RSP.deny);

endmodule : cfp_fuse_protect

// ### testbench/cfp_access_model.sv
`timescale 1ns/1ps
module cfp_access_model
	import cfp_pkg::*;
#(
	parameter bit SMALL_PART = 1'b0
)
(
	// Clock
	input wire logic mclk,
	// Access port
	output cfp_req_t req,
	input wire cfp_rsp_t rsp,
	// Programmer presence
	output logic prog_mode
);
	initial
	begin
		req = '0;
		prog_mode = 1'b0;
	end

	task automatic set_prog(input logic v);
		@(negedge mclk);
		prog_mode = v;
	endtask : set_prog

	// One byte per request; request held until the edge that takes it
	task automatic access(input cfp_kind_t kind, input logic [21:0] addr, input logic [21:0] exec,
		input logic ee, input logic [7:0] wdata, output cfp_rsp_t answer);
		logic [7:0] w;
		w = wdata;
		// Smaller parts keep the block 2 and 3 fuse bits set
		if (SMALL_PART && kind == KIND_PROG_WRITE && addr inside {22'h300008, 22'h30000A, 22'h30000C})
			w = wdata | 8'h0C;
		@(negedge mclk);
		req.valid = 1'b1;
		req.kind = kind;
		req.eeprom = ee;
		req.addr = addr;
		req.exec_addr = exec;
		req.wdata = w;
		@(negedge mclk);
		// The answer stands for one cycle only, so it is taken before the lines drop
		answer = rsp;
		// Released address and data lines show inverted values so stale data cannot pass
		req.valid = 1'b0;
		req.kind = KIND_NONE;
		req.addr = ~addr;
		req.exec_addr = ~exec;
		req.wdata = ~w;
	endtask : access
endmodule : cfp_access_model

// ### testbench/cfp_fuse_protect_tb.sv
`timescale 1ns/1ps
module cfp_fuse_protect_tb;
	import cfp_pkg::*;
	// Arbitrary identity values
	localparam logic [10:0] PART = 11'h5A3;
	localparam logic [4:0] REV = 5'h11;
	logic mclk, rst, ce, prog_mode, stack_fault, stack_reset, debug_pins_reserved, lvp_entry_en;
	cfp_req_t req;
	cfp_rsp_t rsp, r;
	int fail_count = 0;
	int checks_done = 0;
	logic [21:0] cfg_addr [7] = '{22'h300006, 22'h300008, 22'h300009, 22'h30000A, 22'h30000B, 22'h30000C,
		22'h30000D};
	logic [7:0] blank [7] = '{8'h85, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};
	logic [21:0] row_addr [20] = '{22'h0001FF, 22'h000200, 22'h002000, 22'h004000, 22'h007FFF, 22'h000000,
		22'h000100, 22'h000100, 22'h001000, 22'h001000, 22'h002100, 22'h002100, 22'h006000, 22'h004100,
		22'h000000, 22'h000300, 22'h002000, 22'h004000, 22'h006000, 22'h000000};
	logic [21:0] row_exec [20] = '{22'h0, 22'h0, 22'h0, 22'h0, 22'h0, 22'h0, 22'h000050, 22'h002000, 22'h001800,
		22'h004000, 22'h003000, 22'h000000, 22'h008000, 22'h008000, 22'h0, 22'h0, 22'h0, 22'h0, 22'h0, 22'h0};
	logic [19:0] row_ee = 20'h80020;

	cfp_fuse_protect #(.PART_CODE(PART), .REVISION(REV)) dut_u (.MCLK(mclk), .RST(rst), .CE(ce),
		.PROG_MODE(prog_mode), .REQ(req), .RSP(rsp), .STACK_FAULT(stack_fault), .STACK_RESET(stack_reset),
		.DEBUG_PINS_RESERVED(debug_pins_reserved), .LVP_ENTRY_EN(lvp_entry_en));
	cfp_access_model #(.SMALL_PART(1'b0)) model_u (.mclk(mclk), .req(req), .rsp(rsp), .prog_mode(prog_mode));

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	task automatic acc(input cfp_kind_t k, input logic [21:0] a, input logic [21:0] e, input logic ee,
		input logic [7:0] d);
		model_u.access(k, a, e, ee, d, r);
		chk_bit("ack", 1'b1, r.ack);
	endtask : acc

	task automatic rd_chk(input logic [21:0] a, input logic [7:0] exp);
		acc(KIND_TABLE_READ, a, 22'h000000, 1'b0, 8'h00);
		chk_bit("cfg", 1'b1, r.cfg);
		chk_byte("rdata", exp, r.rdata);
	endtask : rd_chk

	task automatic fault_chk(input logic exp);
		@(negedge mclk);
		stack_fault = 1'b1;
		@(negedge mclk);
		chk_bit("stack reset", exp, stack_reset);
		stack_fault = 1'b0;
	endtask : fault_chk

	// Programmer loads the protection fuses, then every row is tried
	task automatic phase(input logic [47:0] vals, input logic [19:0] exp);
		cfp_kind_t k;
		for (int i = 1; i < 7; i++)
			acc(KIND_PROG_WRITE, cfg_addr[i], 22'h0, 1'b0, vals[55 - 8 * i -: 8]);
		for (int i = 0; i < 20; i++)
		begin
			k = (i < 6) ? KIND_PROG_READ : (i < 14) ? KIND_TABLE_READ : KIND_TABLE_WRITE;
			acc(k, row_addr[i], row_exec[i], row_ee[i], 8'hA5);
			chk_bit("deny", exp[i], r.deny);
			chk_byte("rdata", 8'h00, r.rdata);
		end
	endtask : phase

	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		stack_fault = 1'b0;
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		chk_bit("lvp", 1'b1, lvp_entry_en);
		chk_bit("debug", 1'b0, debug_pins_reserved);
		foreach (cfg_addr[i])
			rd_chk(cfg_addr[i], blank[i]);
		rd_chk(22'h3FFFFE, {PART[2:0], REV});
		rd_chk(22'h3FFFFF, PART[10:3]);
		rd_chk(22'h300000, 8'h00);
		// Clock enable low freezes the stack reset output
		ce = 1'b0;
		fault_chk(1'b0);
		ce = 1'b1;
		fault_chk(1'b1);
		acc(KIND_TABLE_WRITE, 22'h300006, 22'h0, 1'b0, 8'h00);
		rd_chk(22'h300006, 8'h00);
		@(negedge mclk);
		chk_bit("debug", 1'b1, debug_pins_reserved);
		chk_bit("lvp", 1'b0, lvp_entry_en);
		fault_chk(1'b0);
		acc(KIND_TABLE_WRITE, 22'h300006, 22'h0, 1'b0, 8'hFF);
		rd_chk(22'h300006, 8'h85);
		acc(KIND_TABLE_WRITE, 22'h300008, 22'h0, 1'b0, 8'h0E);
		acc(KIND_TABLE_WRITE, 22'h300008, 22'h0, 1'b0, 8'h0F);
		rd_chk(22'h300008, 8'h0E);
		acc(KIND_TABLE_WRITE, 22'h300009, 22'h0, 1'b0, 8'h40);
		acc(KIND_TABLE_WRITE, 22'h300009, 22'h0, 1'b0, 8'hFF);
		rd_chk(22'h300009, 8'h40);
		acc(KIND_TABLE_WRITE, 22'h30000B, 22'h0, 1'b0, 8'h00);
		rd_chk(22'h30000B, 8'h20);
		acc(KIND_TABLE_WRITE, 22'h3FFFFE, 22'h0, 1'b0, 8'h00);
		rd_chk(22'h3FFFFE, {PART[2:0], REV});
		acc(KIND_NONE, 22'h300006, 22'h0, 1'b0, 8'h00);
		chk_bit("deny", 1'b1, r.deny);
		acc(KIND_PROG_WRITE, 22'h30000B, 22'h0, 1'b0, 8'h00);
		chk_bit("deny", 1'b1, r.deny);
		model_u.set_prog(1'b1);
		repeat (3) @(negedge mclk);
		acc(KIND_PROG_WRITE, 22'h30000B, 22'h0, 1'b0, 8'h00);
		rd_chk(22'h30000B, 8'h00);
		acc(KIND_TABLE_WRITE, 22'h300006, 22'h0, 1'b0, 8'h00);
		chk_bit("deny", 1'b1, r.deny);
		rd_chk(22'h300006, 8'h85);
		phase(48'h000000000000, 20'hFFABF);
		phase(48'h0A400A600A40, 20'hAE2AA);
		phase(48'hFFFFFFFFFFFF, 20'h00000);
		complete_run();
	end

	initial
	begin
		#100000;
		fail_count++;
		$display("Error watchdog expired");
		complete_run();
	end
endmodule : cfp_fuse_protect_tb
